/* File: design/cgsrp_host.sv */
`timescale 1ns/1ps
`include "cgsrp_defs.svh"
module cgsrp_host (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	cgsrp_if.host            bus,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output wire logic        s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output wire logic        s_axi_wready,
	output wire logic [1:0]  s_axi_bresp,
	output wire logic        s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output wire logic        s_axi_arready,
	output wire logic [31:0] s_axi_rdata,
	output wire logic [1:0]  s_axi_rresp,
	output wire logic        s_axi_rvalid,
	input  wire logic        s_axi_rready
);
	import cgsrp_pkg::*;

	logic        awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
	logic        aw_got_r, w_got_r;   // Write halves captured
	logic [7:0]  awaddr_r;            // Captured write address
	logic [31:0] wdata_r;             // Captured write data
	logic [3:0]  wstrb_r;             // Captured byte enables
	logic [1:0]  bresp_r, rresp_r;
	logic [31:0] rdata_r;
	logic        do_wr;               // Both halves here, commit now
	logic        rd_r, blk_r, go_r;   // Control fields and start pulse
	cgsrp_byte_t cmd_r;               // Command byte for byte mode
	logic [2:0]  len_r;               // Block byte count
	logic [31:0] data_r;              // Transfer bytes, byte 0 low
	logic        nack_r, ref_r;       // Sticky status
	logic [2:0]  sda_q_r;             // Data synchroniser chain
	logic        sda_r;               // Filtered data level
	logic [7:0]  div_r;               // Quarter-bit divider
	logic        tick_r;              // One pulse per quarter bit
	cgsrp_hst_t  st_r;
	cgsrp_seq_t  seq_r;
	logic [1:0]  q_r;                 // Quarter within a symbol
	logic [3:0]  bit_r;               // Bit within byte plus ack
	logic [8:0]  tx_r, rx_r;          // Outgoing and sampled bits
	logic [2:0]  rem_r;               // Bytes left after this one
	logic [1:0]  idx_r;               // Byte slot in data_r
	logic [1:0]  rx_slot_r;           // Slot of the byte being stored; idx_r moves on first
	logic        busy_r, rx_we_r, nack_set_r;
	logic        scl_oe_n_r, sda_oe_n_r, pin_o_r;

	assign do_wr = aw_got_r & w_got_r & ~bvalid_r;

	// Write channels: address and data taken in either order
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			awready_r <= 1'b1;
			wready_r  <= 1'b1;
			aw_got_r  <= 1'b0;
			w_got_r   <= 1'b0;
			awaddr_r  <= 8'h00;
			wdata_r   <= 32'h0;
			wstrb_r   <= 4'h0;
			bvalid_r  <= 1'b0;
			bresp_r   <= 2'h0;
		end
		else
		begin
			if (s_axi_awvalid && awready_r)
			begin
				aw_got_r  <= 1'b1;
				awaddr_r  <= s_axi_awaddr;
				awready_r <= 1'b0;
			end
			if (s_axi_wvalid && wready_r)
			begin
				w_got_r  <= 1'b1;
				wdata_r  <= s_axi_wdata;
				wstrb_r  <= s_axi_wstrb;
				wready_r <= 1'b0;
			end
			if (do_wr)
			begin
				aw_got_r <= 1'b0;
				w_got_r  <= 1'b0;
				bvalid_r <= 1'b1;
				bresp_r  <= (awaddr_r > `CG_OFS_STAT || awaddr_r[1:0] != 2'h0) ? 2'h2 : 2'h0;
			end
			if (bvalid_r && s_axi_bready)
			begin
				bvalid_r  <= 1'b0;
				awready_r <= 1'b1;
				wready_r  <= 1'b1;
			end
		end
	end

	// Read channel: data one cycle after the address is taken
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			arready_r <= 1'b1;
			rvalid_r  <= 1'b0;
			rdata_r   <= 32'h0;
			rresp_r   <= 2'h0;
		end
		else if (s_axi_arvalid && arready_r)
		begin
			arready_r <= 1'b0;
			rvalid_r  <= 1'b1;
			rresp_r   <= 2'h0;
			if (s_axi_araddr == `CG_OFS_CTRL)
				rdata_r <= {29'h0, blk_r, rd_r, 1'b0};
			else if (s_axi_araddr == `CG_OFS_CMD)
				rdata_r <= {24'h0, cmd_r};
			else if (s_axi_araddr == `CG_OFS_LEN)
				rdata_r <= {29'h0, len_r};
			else if (s_axi_araddr == `CG_OFS_DATA)
				rdata_r <= data_r;
			else if (s_axi_araddr == `CG_OFS_STAT)
				rdata_r <= {29'h0, ref_r, nack_r, busy_r};
			else
			begin
				rdata_r <= 32'h0;
				rresp_r <= 2'h2; // Unmapped
			end
		end
		else if (rvalid_r && s_axi_rready)
		begin
			rvalid_r  <= 1'b0;
			arready_r <= 1'b1;
		end
	end

	// Orders from software; hardware status sets win over clears
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rd_r   <= 1'b0;
			blk_r  <= 1'b0;
			go_r   <= 1'b0;
			cmd_r  <= 8'h00;
			len_r  <= 3'h0;
			data_r <= 32'h0;
			nack_r <= 1'b0;
			ref_r  <= 1'b0;
		end
		else
		begin
			go_r <= 1'b0;
			if (do_wr && awaddr_r == `CG_OFS_CTRL && wstrb_r[0])
			begin
				rd_r  <= wdata_r[`CG_CTRL_RD];
				blk_r <= wdata_r[`CG_CTRL_BLK];
				if (wdata_r[`CG_CTRL_GO] && !busy_r)
				begin
					nack_r <= 1'b0;
					// Byte writes to the factory test bytes never reach the wire
					if (!wdata_r[`CG_CTRL_RD] && !wdata_r[`CG_CTRL_BLK]
						&& (cmd_r == `CG_TEST1_IDX || cmd_r == `CG_TEST2_IDX))
						ref_r <= 1'b1; // [R3]
					else
					begin
						ref_r <= 1'b0;
						go_r  <= 1'b1;
					end
				end
			end
			if (do_wr && awaddr_r == `CG_OFS_CMD && wstrb_r[0])
				cmd_r <= wdata_r[7:0];
			if (do_wr && awaddr_r == `CG_OFS_LEN && wstrb_r[0])
				len_r <= (wdata_r[2:0] > `CG_LEN_MAX) ? `CG_LEN_MAX : wdata_r[2:0];
			for (int i = 0; i < 4; i++)
				if (do_wr && awaddr_r == `CG_OFS_DATA && wstrb_r[i])
					data_r[i*8 +: 8] <= wdata_r[i*8 +: 8];
			if (rx_we_r)
				data_r[{rx_slot_r, 3'b000} +: 8] <= rx_r[8:1];
			if (nack_set_r)
				nack_r <= 1'b1;
		end
	end

	// Data sampling and quarter-bit divider
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			sda_q_r <= 3'h7;
			sda_r   <= 1'b1;
			div_r   <= 8'h00;
			tick_r  <= 1'b0;
		end
		else
		begin
			sda_q_r <= {sda_q_r[1:0], bus.sda};
			if (sda_q_r[1] == sda_q_r[2])
				sda_r <= sda_q_r[2];
			tick_r <= (div_r == 8'(`CG_QTR_CYC - 1));
			div_r  <= (div_r == 8'(`CG_QTR_CYC - 1)) ? 8'h00 : div_r + 8'h01;
		end
	end

	// Master engine: start, bytes of nine bits, stop; four quarters each
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			st_r <= hs_idle;
			seq_r <= sq_aw;
			q_r <= 2'h0;
			bit_r <= 4'h0;
			tx_r <= 9'h1FF;
			rx_r <= 9'h1FF;
			rem_r <= 3'h0;
			idx_r <= 2'h0;
			rx_slot_r <= 2'h0;
			busy_r <= 1'b0;
			rx_we_r <= 1'b0;
			nack_set_r <= 1'b0;
			scl_oe_n_r <= 1'b1;
			sda_oe_n_r <= 1'b1;
			pin_o_r <= 1'b0;
		end
		else
		begin
			rx_we_r    <= 1'b0;
			nack_set_r <= 1'b0;
			if (st_r == hs_idle)
			begin
				if (go_r)
				begin
					st_r   <= hs_start;
					seq_r  <= sq_aw;
					q_r    <= 2'h0;
					busy_r <= 1'b1;
				end
			end
			else if (tick_r)
			begin
				q_r <= q_r + 2'h1;
				case (st_r)
				hs_start:
					case (q_r)
					2'h0: sda_oe_n_r <= 1'b1;
					2'h1: scl_oe_n_r <= 1'b1;
					2'h2: sda_oe_n_r <= 1'b0;
					default:
					begin
						scl_oe_n_r <= 1'b0;
						st_r  <= hs_byte;
						bit_r <= 4'h0;
						tx_r  <= {7'(`CG_SLAVE_ADDR >> 1), seq_r == sq_ar, 1'b1}; // [R6]
					end
					endcase
				hs_byte:
					case (q_r)
					2'h0: sda_oe_n_r <= tx_r[8];
					2'h1: scl_oe_n_r <= 1'b1;
					2'h2: rx_r <= {rx_r[7:0], sda_r};
					default:
					begin
						scl_oe_n_r <= 1'b0;
						tx_r  <= {tx_r[7:0], 1'b1};
						bit_r <= bit_r + 4'h1;
						if (bit_r == 4'h8)
						begin
							bit_r <= 4'h0;
							// A refused ack on a written byte ends the frame
							if (rx_r[0] && seq_r != sq_rc && seq_r != sq_rd)
							begin
								nack_set_r <= 1'b1;
								st_r <= hs_stop;
							end
							else
								case (seq_r)
								sq_aw:
								begin
									tx_r  <= {blk_r ? `CG_BLK_CMD : cmd_r, 1'b1}; // [R7] [R8]
									seq_r <= sq_cmd;
								end
								sq_cmd:
									if (rd_r)
									begin
										st_r  <= hs_start;
										seq_r <= sq_ar;
									end
									else
									begin
										tx_r  <= {blk_r ? {5'h0, len_r} : data_r[7:0], 1'b1};
										rem_r <= blk_r ? len_r : 3'h0;
										idx_r <= 2'h0;
										seq_r <= sq_wd;
									end
								sq_wd:
									if (rem_r == 3'h0)
										st_r <= hs_stop;
									else
									begin
										tx_r  <= {data_r[{idx_r, 3'b000} +: 8], 1'b1};
										idx_r <= idx_r + 2'h1;
										rem_r <= rem_r - 3'h1;
									end
								sq_ar:
								begin
									tx_r  <= {8'hFF, blk_r ? (len_r == 3'h0) : 1'b1};
									rem_r <= blk_r ? len_r : 3'h0;
									idx_r <= 2'h0;
									seq_r <= blk_r ? sq_rc : sq_rd;
								end
								sq_rc:
									if (rem_r == 3'h0)
										st_r <= hs_stop;
									else
									begin
										tx_r  <= {8'hFF, rem_r == 3'h1};
										rem_r <= rem_r - 3'h1;
										seq_r <= sq_rd;
									end
								default:
								begin
									rx_we_r <= 1'b1;
									rx_slot_r <= idx_r;
									if (rem_r == 3'h0)
										st_r <= hs_stop;
									else
									begin
										tx_r  <= {8'hFF, rem_r == 3'h1};
										idx_r <= idx_r + 2'h1;
										rem_r <= rem_r - 3'h1;
									end
								end
								endcase
						end
					end
					endcase
				default:
					case (q_r)
					2'h0: sda_oe_n_r <= 1'b0;
					2'h1: scl_oe_n_r <= 1'b1;
					2'h2: sda_oe_n_r <= 1'b1;
					default:
					begin
						st_r   <= hs_idle;
						busy_r <= 1'b0;
					end
					endcase
				endcase
			end
		end
	end

	assign bus.host_scl_oe_n = scl_oe_n_r;
	assign bus.host_sda_oe_n = sda_oe_n_r;
	assign bus.host_scl_o    = pin_o_r;
	assign bus.host_sda_o    = pin_o_r;
	assign s_axi_awready = awready_r;
	assign s_axi_wready  = wready_r;
	assign s_axi_bresp   = bresp_r;
	assign s_axi_bvalid  = bvalid_r;
	assign s_axi_arready = arready_r;
	assign s_axi_rdata   = rdata_r;
	assign s_axi_rresp   = rresp_r;
	assign s_axi_rvalid  = rvalid_r;
endmodule

/* File: design/cgsrp_defs.svh */
`ifndef CGSRP_DEFS_SVH
`define CGSRP_DEFS_SVH
// Serial link
`define CG_SLAVE_ADDR 8'hD2
`define CG_BLK_CMD    8'h00
`define CG_BLK_COUNT  8'h0D
`define CG_ID_IDX     7'h0C
`define CG_TEST1_IDX  8'h51
`define CG_TEST2_IDX  8'h52
`define CG_REG_RESET  8'h00
// Timing: one quarter of a serial bit
`define CG_CLK_MHZ    10
`define CG_QTR_NS     2500
`define CG_QTR_CYC    ((`CG_QTR_NS * `CG_CLK_MHZ + 999) / 1000)
// Controller register offsets
`define CG_OFS_CTRL   8'h00
`define CG_OFS_CMD    8'h04
`define CG_OFS_LEN    8'h08
`define CG_OFS_DATA   8'h0C
`define CG_OFS_STAT   8'h10
// Field positions
`define CG_CTRL_GO    0
`define CG_CTRL_RD    1
`define CG_CTRL_BLK   2
`define CG_STAT_BUSY  0
`define CG_STAT_NACK  1
`define CG_STAT_REF   2
`define CG_LEN_MAX    3'h4
`endif

/* File: design/cgsrp_pkg.sv */
package cgsrp_pkg;
	typedef logic [7:0] cgsrp_byte_t;
	typedef logic [6:0] cgsrp_idx_t;
	typedef enum logic [2:0] {ds_idle, ds_addr, ds_wbyte, ds_ack, ds_rbyte, ds_rack} cgsrp_dst_t;
	typedef enum logic [1:0] {hs_idle, hs_start, hs_byte, hs_stop} cgsrp_hst_t;
	typedef enum logic [2:0] {sq_aw, sq_cmd, sq_wd, sq_ar, sq_rc, sq_rd} cgsrp_seq_t;
endpackage

/* File: design/cgsrp_if.sv */
`timescale 1ns/1ps
interface cgsrp_if;
	logic host_scl_o;    // Level driven while enabled
	logic host_scl_oe_n; // Low while host pulls the clock
	logic host_sda_o;    // Level driven while enabled
	logic host_sda_oe_n; // Low while host drives data
	logic dev_sda_o;     // Level driven while enabled
	logic dev_sda_oe_n;  // Low while device drives data
	logic scl;           // Resolved clock wire, pulled up
	logic sda;           // Resolved data wire, pulled up
	// Open-drain wires with pull-up: any enabled low driver wins
	assign scl = host_scl_oe_n | host_scl_o;
	assign sda = (host_sda_oe_n | host_sda_o) & (dev_sda_oe_n | dev_sda_o);
	modport host (output host_scl_o, host_scl_oe_n, host_sda_o, host_sda_oe_n, input scl, sda);
	modport dev (output dev_sda_o, dev_sda_oe_n, input scl, sda);
endinterface

/* File: design/cgsrp_device.sv */
`timescale 1ns/1ps
`include "cgsrp_defs.svh"
// What this block does
// R1 - ID upper nibble returns fixed sub-part code
// R2 - ID lower nibble returns fixed revision code
// R3 - Host never writes factory test registers
// R4 - Registers reached only over serial bus; the core_idx/core_data port here also reads them
// R5 - Block and byte-data reads and writes
// R6 - Respond only to slave address D2
// R7 - Block transfers use command zero
// R8 - Byte command selects the register index
module cgsrp_device #(
	parameter logic [3:0] SUB_CODE = 4'hA, // Arbitrary value
	parameter logic [3:0] REV_CODE = 4'h5  // Arbitrary value
) (
	input  wire logic                aclk,
	input  wire logic                aresetn,
	cgsrp_if.dev                     bus,
	input  wire cgsrp_pkg::cgsrp_idx_t  core_idx,
	output wire cgsrp_pkg::cgsrp_byte_t core_data,
	output wire logic                reg_written,
	output wire logic                busy
);
	import cgsrp_pkg::*;

	logic [2:0]  scl_q_r, sda_q_r;      // Clock and data synchroniser chains
	logic        scl_r, sda_r;          // Filtered clock and data levels
	logic        scl_d_r, sda_d_r;      // Filtered levels one cycle ago
	cgsrp_dst_t  st_r;                  // Slave state
	logic [2:0]  bit_r;                 // Bit within byte
	cgsrp_byte_t shift_r, wr_dat_r;     // Bit shifter; register write data
	logic        phase_r, rd_r;         // Ack slot half; transfer reads
	logic        cmd_ph_r, cnt_ph_r;    // Next written byte is command or count
	logic        blk_r, first_r;        // Block mode; next read byte is count
	cgsrp_idx_t  ptr_r, wr_idx_r;       // Register pointer; write index
	logic        ptr_ok_r, wr_en_r;     // Pointer inside map; write strobe
	logic        sda_oe_n_r, sda_o_r;   // Data pin enable, low drives; its level
	cgsrp_byte_t mem_r [0:127];         // Register storage
	cgsrp_byte_t core_data_r;           // Core-side readback
	logic        reg_written_r, busy_r; // Write pulse and busy level
	cgsrp_byte_t tx_byte, rx_byte;      // Next read byte; byte done at this rise
	logic        rise, fall;            // Filtered clock edges
	logic        start_ev, stop_ev;     // Bus start and stop conditions

	// Three-stage sampling; a level counts once stages two and three agree
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			scl_q_r <= 3'h7;
			sda_q_r <= 3'h7;
			scl_r   <= 1'b1;
			sda_r   <= 1'b1;
			scl_d_r <= 1'b1;
			sda_d_r <= 1'b1;
		end
		else
		begin
			scl_q_r <= {scl_q_r[1:0], bus.scl};
			sda_q_r <= {sda_q_r[1:0], bus.sda};
			if (scl_q_r[1] == scl_q_r[2])
				scl_r <= scl_q_r[2];
			if (sda_q_r[1] == sda_q_r[2])
				sda_r <= sda_q_r[2];
			scl_d_r <= scl_r;
			sda_d_r <= sda_r;
		end
	end

	// Edges and bus conditions from filtered levels
	assign rise     = scl_r & ~scl_d_r;
	assign fall     = ~scl_r & scl_d_r;
	assign start_ev = scl_r & scl_d_r & sda_d_r & ~sda_r;
	assign stop_ev  = scl_r & scl_d_r & ~sda_d_r & sda_r;
	assign rx_byte  = {shift_r[6:0], sda_r};

	// Read source; the ID byte is not storage, so no write can change it
	always_comb
	begin
		if (first_r)
			tx_byte = `CG_BLK_COUNT;
		else if (ptr_r == `CG_ID_IDX)
			tx_byte = {SUB_CODE, REV_CODE}; // [R1] [R2]
		else
			tx_byte = mem_r[ptr_r];
	end

	// Slave protocol engine; start and stop override any state
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			st_r       <= ds_idle;
			bit_r      <= 3'h0;
			shift_r    <= 8'h00;
			phase_r    <= 1'b0;
			rd_r       <= 1'b0;
			cmd_ph_r   <= 1'b0;
			cnt_ph_r   <= 1'b0;
			blk_r      <= 1'b0;
			first_r    <= 1'b0;
			ptr_r      <= 7'h00;
			ptr_ok_r   <= 1'b0;
			wr_en_r    <= 1'b0;
			wr_idx_r   <= 7'h00;
			wr_dat_r   <= 8'h00;
			sda_oe_n_r <= 1'b1;
		end
		else
		begin
			wr_en_r <= 1'b0;
			if (start_ev)
			begin
				// Repeated start keeps pointer and mode
				st_r       <= ds_addr;
				bit_r      <= 3'h0;
				sda_oe_n_r <= 1'b1;
			end
			else if (stop_ev)
			begin
				st_r       <= ds_idle;
				sda_oe_n_r <= 1'b1;
			end
			else
				case (st_r)
				ds_addr, ds_wbyte:
					if (rise)
					begin
						shift_r <= rx_byte;
						bit_r   <= bit_r + 3'h1;
						if (bit_r == 3'h7)
						begin
							st_r    <= ds_ack;
							phase_r <= 1'b0;
							if (st_r == ds_addr)
							begin
								// Foreign address: stay silent until next start
								if (rx_byte[7:1] != `CG_SLAVE_ADDR >> 1)
									st_r <= ds_idle; // [R6]
								rd_r     <= rx_byte[0];
								cmd_ph_r <= ~rx_byte[0];
								first_r  <= rx_byte[0] & blk_r; // [R5]
								if (rx_byte[0] & blk_r)
								begin
									ptr_r    <= 7'h00;
									ptr_ok_r <= 1'b1;
								end
							end
							else if (cmd_ph_r)
							begin
								cmd_ph_r <= 1'b0;
								blk_r    <= (rx_byte == `CG_BLK_CMD); // [R5]
								cnt_ph_r <= (rx_byte == `CG_BLK_CMD);
								ptr_r    <= rx_byte[6:0]; // [R8]
								ptr_ok_r <= ~rx_byte[7];
							end
							else if (cnt_ph_r)
								cnt_ph_r <= 1'b0; // Count only frames the data
							else
							begin
								wr_en_r  <= ptr_ok_r; // [R4]
								wr_idx_r <= ptr_r;
								wr_dat_r <= rx_byte;
								ptr_r    <= ptr_r + 7'h01;
								if (ptr_r == 7'h7F)
									ptr_ok_r <= 1'b0;
							end
						end
					end
				ds_ack:
					if (fall)
					begin
						if (!phase_r)
						begin
							sda_oe_n_r <= 1'b0;
							phase_r    <= 1'b1;
						end
						else if (rd_r)
						begin
							// First read bit goes out on the fall ending the ack
							st_r       <= ds_rbyte;
							bit_r      <= 3'h0;
							sda_oe_n_r <= tx_byte[7];
							shift_r    <= {tx_byte[6:0], 1'b1};
						end
						else
						begin
							st_r       <= ds_wbyte;
							bit_r      <= 3'h0;
							sda_oe_n_r <= 1'b1;
						end
					end
				ds_rbyte:
					if (fall)
					begin
						if (bit_r == 3'h0)
						begin
							sda_oe_n_r <= tx_byte[7];
							shift_r    <= {tx_byte[6:0], 1'b1};
						end
						else
						begin
							sda_oe_n_r <= shift_r[7];
							shift_r    <= {shift_r[6:0], 1'b1};
						end
					end
					else if (rise)
					begin
						bit_r <= bit_r + 3'h1;
						if (bit_r == 3'h7)
							st_r <= ds_rack;
					end
				ds_rack:
					if (fall)
						sda_oe_n_r <= 1'b1; // Free the line for the master
					else if (rise)
					begin
						if (!sda_r)
						begin
							st_r  <= ds_rbyte;
							bit_r <= 3'h0;
							if (first_r)
								first_r <= 1'b0;
							else
								ptr_r <= ptr_r + 7'h01;
						end
						else
							st_r <= ds_idle; // Master done
					end
				default:
					st_r <= ds_idle;
				endcase
		end
	end

	// Register storage; the ID index is never stored
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			for (int i = 0; i < 128; i++)
				mem_r[i] <= `CG_REG_RESET;
		else if (wr_en_r && wr_idx_r != `CG_ID_IDX)
			mem_r[wr_idx_r] <= wr_dat_r; // [R4] [R1]
	end

	// Core-side view, one cycle behind the index
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			core_data_r   <= 8'h00;
			reg_written_r <= 1'b0;
			busy_r        <= 1'b0;
			sda_o_r       <= 1'b0;
		end
		else
		begin
			if (core_idx == `CG_ID_IDX)
				core_data_r <= {SUB_CODE, REV_CODE};
			else
				core_data_r <= mem_r[core_idx];
			reg_written_r <= wr_en_r & (wr_idx_r != `CG_ID_IDX);
			busy_r        <= (st_r != ds_idle);
			sda_o_r       <= 1'b0;
		end
	end

	assign bus.dev_sda_oe_n = sda_oe_n_r;
	assign bus.dev_sda_o    = sda_o_r;
	assign core_data        = core_data_r;
	assign reg_written      = reg_written_r;
	assign busy             = busy_r;
endmodule

/* File: bench/cgsrp_props.sv */
`timescale 1ns/1ps
// Wire checks on the shared two-wire link
module cgsrp_props (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic scl,
	input wire logic sda,
	input wire logic host_sda_oe_n,
	input wire logic dev_sda_oe_n
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	dev_setup_a: assert property ($changed(dev_sda_oe_n) |-> !scl)
		else $error("device data moved with clock high");
	bus_conflict_a: assert property (!dev_sda_oe_n && scl |-> host_sda_oe_n)
		else $error("host and device both drive data");
	start_hold_a: assert property ($fell(sda) && scl |-> scl[*8] ##[12:22] !scl)
		else $error("start not followed by clock low");
	stop_idle_a: assert property ($rose(sda) && scl |-> (sda && scl)[*8])
		else $error("bus not idle after stop");
	clk_high_a: assert property ($rose(scl) |-> scl[*8])
		else $error("clock high phase too short");
	clk_low_a: assert property ($fell(scl) |-> (!scl)[*8])
		else $error("clock low phase too short");
	dev_release_a: assert property ($fell(dev_sda_oe_n) |-> ##[1:1000] dev_sda_oe_n)
		else $error("device held data too long");
	host_stop_a: assert property ($rose(host_sda_oe_n) && scl |-> $past(scl, 20))
		else $error("host released data in short clock high");
endmodule

/* File: bench/testbench.sv */
`timescale 1ns/1ps
module testbench;
	import cgsrp_pkg::*;
	typedef struct {logic [6:0] idx; logic [7:0] wd; logic [7:0] ex;} cgsrp_row_t;
	localparam logic [3:0] SUB = 4'h6; // Arbitrary value
	localparam logic [3:0] REV = 4'h9; // Arbitrary value
	logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata, rd;
	logic        awready, wready, bvalid, arready, rvalid, reg_written, busy;
	logic [1:0]  bresp, rresp, rs;
	cgsrp_idx_t  core_idx;
	cgsrp_byte_t core_data;
	int          err_total = 0, compares = 0, wr_cnt = 0, ex_cnt = 0, c0, i;
	cgsrp_row_t  rows [4] = '{'{7'h01, 8'h3C, 8'h3C}, '{7'h0B, 8'hFF, 8'hFF},
		'{7'h0D, 8'h81, 8'h81}, '{7'h0C, 8'h77, {SUB, REV}}};
	cgsrp_if bus ();
	cgsrp_device #(.SUB_CODE(SUB), .REV_CODE(REV)) i_cgsrp_device (.aclk(aclk),
		.aresetn(aresetn), .bus(bus), .core_idx(core_idx), .core_data(core_data),
		.reg_written(reg_written), .busy(busy));
	cgsrp_host i_cgsrp_host (.aclk(aclk), .aresetn(aresetn), .bus(bus),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready));
	cgsrp_props i_cgsrp_props (.aclk(aclk), .aresetn(aresetn), .scl(bus.scl),
		.sda(bus.sda), .host_sda_oe_n(bus.host_sda_oe_n), .dev_sda_oe_n(bus.dev_sda_oe_n));
	// Free-running bus clock
	initial
	begin
		aclk = 1'b0;
		forever #50 aclk = ~aclk;
	end
	// Stored writes seen at the device side
	always @(posedge aclk)
		if (reg_written === 1'b1)
			wr_cnt++;
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] ex);
		compares++;
		if (seen !== ex)
		begin
			err_total++;
			$display("unexpected %s: expected %h seen %h", nm, ex, seen);
		end
	endtask
	// Write one word; both halves offered together, response taken last
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
		end
		while (bvalid !== 1'b1);
		rs = bresp;
		bready <= 1'b0;
	endtask
	task automatic rdreg(input logic [7:0] a);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (arready)
				arvalid <= 1'b0;
		end
		while (rvalid !== 1'b1);
		rd = rdata;
		rs = rresp;
		rready <= 1'b0;
	endtask
	// Start a transfer and poll status until it is idle again
	task automatic go(input logic [31:0] c);
		wr(8'h00, c);
		do
			rdreg(8'h10);
		while (rd[0] !== 1'b0);
	endtask
	task automatic peek(input logic [6:0] idx, input logic [7:0] ex);
		core_idx <= idx;
		repeat (2) @(posedge aclk);
		chk("core data", {24'h0, core_data}, {24'h0, ex});
	endtask
	task automatic print_verdict;
		$display("compares %0d mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// Hang guard: about twice as long as the whole sequence should need
	initial
	begin
		repeat (80000) @(posedge aclk);
		err_total++;
		print_verdict;
	end
	initial
	begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
		{awaddr, araddr, wdata} = 48'h0;
		core_idx = 7'h00;
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		rdreg(8'h10);
		chk("status after reset", rd, 32'h0);
		$display("reset test done");
		// Byte write then byte read of each row's index
		foreach (rows[k])
		begin
			if (rows[k].idx != 7'h0C)
				ex_cnt++;
			wr(8'h04, {25'h0, rows[k].idx});
			wr(8'h0C, {24'h0, rows[k].wd});
			go(32'h1);
			chk("nack", {31'h0, rd[1]}, 32'h0);
			go(32'h3);
			rdreg(8'h0C);
			chk("byte read", {24'h0, rd[7:0]}, {24'h0, rows[k].ex});
			peek(rows[k].idx, rows[k].ex);
		end
		chk("id code", {24'h0, core_data}, {24'h0, SUB, REV});
		chk("device idle", {31'h0, busy}, 32'h0);
		chk("write pulses", wr_cnt, ex_cnt);
		$display("byte transfer test done");
		// Block write of four bytes from index zero, then block read back
		wr(8'h08, 32'h4);
		wr(8'h04, 32'h0);
		wr(8'h0C, 32'h44332211);
		go(32'h5);
		for (i = 0; i < 4; i++)
			peek(i[6:0], 8'(8'h11 * (i + 1)));
		wr(8'h0C, 32'h0);
		go(32'h7);
		rdreg(8'h0C);
		chk("block read", rd, 32'h44332211);
		rdreg(8'h00);
		chk("control readback", rd, 32'h6);
		$display("block transfer test done");
		// Writes to the factory test bytes are refused with no wire activity
		for (i = 8'h51; i <= 8'h52; i++)
		begin
			c0 = wr_cnt;
			wr(8'h04, i);
			go(32'h1);
			chk("refused flag", {29'h0, rd[2:0]}, 32'h4);
			chk("refused pulses", wr_cnt, c0);
		end
		$display("refused write test done");
		// Unmapped and unaligned offsets answer with an error
		wr(8'h14, 32'h1);
		chk("unmapped bresp", {30'h0, rs}, 32'h2);
		wr(8'h02, 32'h1);
		chk("unaligned bresp", {30'h0, rs}, 32'h2);
		rdreg(8'h14);
		chk("unmapped rresp", {30'h0, rs}, 32'h2);
		chk("unmapped rdata", rd, 32'h0);
		wr(8'h08, 32'h7);
		rdreg(8'h08);
		chk("length clamp", rd, 32'h4);
		$display("unmapped test done");
		// Mid-run reset clears device storage and host status
		aresetn <= 1'b0;
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		peek(7'h00, 8'h00);
		rdreg(8'h10);
		chk("status after mid reset", rd, 32'h0);
		$display("mid-run reset test done");
		print_verdict;
	end
endmodule
